// ### rtl/ext_irq_pkg.sv
// Package for the external interrupt latch: offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package ext_irq_pkg;
  localparam logic [7:0] status_control_offset = 8'h18;
  localparam logic [7:0] option_control_offset = 8'h1c;
  localparam int         pending_bit            = 3;
  localparam int         ack_bit                = 2;
  localparam int         mask_bit               = 1;
  localparam int         mode_bit               = 0;
  localparam int         edge_flag_bit          = 2;
  localparam int         shared_enable_bit      = 1;
  localparam int         pullup_disable_bit     = 0;
  localparam logic       mask_reset             = 1'b0;
  localparam logic       mode_reset             = 1'b0;
  localparam logic       shared_enable_reset    = 1'b0;
  localparam logic       pullup_disable_reset   = 1'b0;
  localparam int         sync_stages            = 3;
  localparam logic [1:0] htrans_nonseq          = 2'h2;
  localparam logic [1:0] hsize_word             = 2'h2;
endpackage

// ### rtl/pin_sync.sv
// Three-stage pin synchroniser; a change counts once stages two and three agree.
// Assumes asynchronous pin inputs and a single bus clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Pin in, filtered level out
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // Chain, reset to idle-high
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Level follows only when later stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b1;
    end else if (ce && (s2 == s3)) begin
      level <= s3;
    end
  end
endmodule
`default_nettype wire

// ### rtl/external_interrupt_latch.sv
// External interrupt latch with AHB-Lite status/control and option/control registers.
// Assumes the CPU supplies vector fetch, break state, break clear enable and global mask.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Latch sets on falling interrupt pin; cleared by vector fetch, acknowledge or reset.
// RULE2: Level mode keeps request until acknowledged and pin high, any order.
// RULE3: Acknowledge bit write-one clears like vector fetch; always reads zero.
// RULE4: Falling edges after acknowledge latch a fresh request.
// RULE5: Unmasked latched request goes to CPU, vector at FFF8/FFF9.
// RULE6: Reset clears latch and mode bit even with pin low.
// RULE7: Edge mode: falling edges only; acknowledge clears immediately.
// RULE8: Pending flag reads request state regardless of unit mask.
// RULE9: Mask bit one blocks requests from CPU; reset clears it.
// RULE10: Pin pullup connected while pullup disable bit is zero.
// RULE11: Shared pin is a source only with USB off and enable set.
// RULE12: Shared pin ORed into the same latch, same control.
// RULE13: Enable forces shared pin to input with pullup on.
// RULE14: Shared pin edge sets flag; option register read clears it.
// RULE15: In break with clear enable, acknowledge clears, stays cleared.
// RULE16: In break without clear enable, acknowledge writes are ignored.
// RULE17: Software should mask in service routine when level sensitive.
// RULE18: Current pin level offered to branch-on-level instructions.
// RULE19: CPU global mask also blocks this unit's request.
// RULE20: Pins synchronised before edge detection; falling is high then low.
module external_interrupt_latch (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins
  input  wire logic        irq_pin_n,
  input  wire logic        shared_port_pin,
  output logic             pin_pullup_on,
  output logic             shared_pin_pullup_on,
  output logic             shared_pin_force_input,
  // CPU side
  input  wire logic        vector_fetch,
  input  wire logic        break_state,
  input  wire logic        break_clear_enable,
  input  wire logic        ccr_int_mask,
  input  wire logic        usb_function_enable,
  output logic             cpu_irq_request,
  output logic             pin_level
);
  import ext_irq_pkg::*;

  localparam int src_count = 2;

  // Pin sampling, index 0 dedicated pin, index 1 shared pin
  logic [src_count-1:0] pin_raw;
  logic [src_count-1:0] src_lvl;
  logic [src_count-1:0] src_edge;
  logic                 irq_lvl;
  logic                 shared_lvl;
  logic                 irq_fall;
  logic                 shared_fall;

  // Register state
  logic                 latch;
  logic                 ack_held;
  logic                 unit_request_mask;
  logic                 mode;
  logic                 shared_pin_int_enable;
  logic                 shared_pin_edge_flag;
  logic                 pin_pullup_disable;

  // Bus decode
  logic                 ap_take;
  logic                 ap_read;
  logic                 ph_valid;
  logic                 ph_write;
  logic [7:0]           ph_addr;
  logic                 wr_status;
  logic                 wr_option;
  logic                 opt_read;
  logic [31:0]          next_hrdata;

  // Request path
  logic                 shared_active;
  logic                 src_level;
  logic                 src_fall;
  logic                 sw_ack;
  logic                 ack_pulse;
  logic                 clear_ok;
  logic                 level_hold;
  logic                 next_request;

  assign pin_raw = {shared_port_pin, irq_pin_n};

  // One synchroniser and edge detector per source
  for (genvar g = 0; g < src_count; g++) begin : g_src
    logic prev;

    pin_sync u_sync (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .pin   (pin_raw[g]),
      .level (src_lvl[g])
    ); // RULE20

    always_ff @(posedge clk) begin
      if (rst) begin
        prev <= 1'b1;
      end else if (ce) begin
        prev <= src_lvl[g];
      end
    end

    assign src_edge[g] = prev && !src_lvl[g]; // RULE20
  end

  // Source selection
  assign irq_lvl       = src_lvl[0];
  assign shared_lvl    = src_lvl[1];
  assign irq_fall      = src_edge[0];
  assign shared_active = shared_pin_int_enable && !usb_function_enable; // RULE11
  assign shared_fall   = shared_active && src_edge[1]; // RULE11
  assign src_level     = !irq_lvl || (shared_active && !shared_lvl); // RULE12
  assign src_fall      = irq_fall || shared_fall; // RULE12

  // Address phase qualifiers
  assign ap_take = ce && hready && hsel && (htrans == htrans_nonseq) && (hsize == {1'b0, hsize_word});
  assign ap_read = ap_take && !hwrite;

  // Data phase valid
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_valid <= 1'b0;
    end else if (ce && hready) begin
      ph_valid <= ap_take;
    end
  end

  // Data phase direction
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_write <= 1'b0;
    end else if (ce && hready) begin
      ph_write <= hwrite;
    end
  end

  // Data phase address
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_addr <= 8'h00;
    end else if (ce && hready) begin
      ph_addr <= haddr[7:0];
    end
  end

  // Register access strobes
  assign wr_status = ph_valid && ph_write && (ph_addr == status_control_offset);
  assign wr_option = ph_valid && ph_write && (ph_addr == option_control_offset);
  assign opt_read  = ap_read && (haddr[7:0] == option_control_offset); // RULE14

  // Acknowledge and request terms
  assign clear_ok     = !break_state || break_clear_enable; // RULE15 RULE16
  assign sw_ack       = wr_status && hwdata[ack_bit] && clear_ok; // RULE3 RULE16
  assign ack_pulse    = vector_fetch || sw_ack; // RULE1
  assign level_hold   = mode && src_level; // RULE2
  assign next_request = latch && !unit_request_mask && !ccr_int_mask; // RULE5 RULE9 RULE19

  // Interrupt latch; a new edge wins over any clear except reset
  always_ff @(posedge clk) begin
    if (rst) begin
      latch <= 1'b0; // RULE6
    end else if (ce) begin
      if (src_fall) begin
        latch <= 1'b1; // RULE1 RULE4
      end else if (ack_pulse && !level_hold) begin
        latch <= 1'b0; // RULE7
      end else if (level_hold && !ack_held) begin
        latch <= 1'b1; // RULE2
      end else if (ack_held && !level_hold) begin
        latch <= 1'b0; // RULE2
      end
    end
  end

  // Acknowledge taken while a level source is still low
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_held <= 1'b0;
    end else if (ce) begin
      if (src_fall || !level_hold) begin
        ack_held <= 1'b0; // RULE4
      end else if (ack_pulse) begin
        ack_held <= 1'b1; // RULE2
      end
    end
  end

  // Unit mask
  always_ff @(posedge clk) begin
    if (rst) begin
      unit_request_mask <= mask_reset; // RULE9
    end else if (ce && wr_status) begin
      unit_request_mask <= hwdata[mask_bit]; // RULE9
    end
  end

  // Sensitivity select
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= mode_reset; // RULE6
    end else if (ce && wr_status) begin
      mode <= hwdata[mode_bit];
    end
  end

  // Shared pin enable
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_pin_int_enable <= shared_enable_reset;
    end else if (ce && wr_option) begin
      shared_pin_int_enable <= hwdata[shared_enable_bit];
    end
  end

  // Pullup disable
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_pullup_disable <= pullup_disable_reset;
    end else if (ce && wr_option) begin
      pin_pullup_disable <= hwdata[pullup_disable_bit];
    end
  end

  // Shared pin edge flag, set beats read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_pin_edge_flag <= 1'b0;
    end else if (ce) begin
      if (shared_fall) begin
        shared_pin_edge_flag <= 1'b1; // RULE14
      end else if (opt_read) begin
        shared_pin_edge_flag <= 1'b0; // RULE14
      end
    end
  end

  // Read data for the address phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (ap_read) begin
      if (haddr[7:0] == status_control_offset) begin
        next_hrdata[pending_bit] = latch; // RULE8
        next_hrdata[ack_bit]     = 1'b0; // RULE3
        next_hrdata[mask_bit]    = unit_request_mask;
        next_hrdata[mode_bit]    = mode;
      end else if (haddr[7:0] == option_control_offset) begin
        next_hrdata[edge_flag_bit]      = shared_pin_edge_flag;
        next_hrdata[shared_enable_bit]  = shared_pin_int_enable;
        next_hrdata[pullup_disable_bit] = pin_pullup_disable;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && hready) begin
      hrdata <= next_hrdata;
    end
  end

  // Ready, never stretched
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // Response, always OKAY
  always_ff @(posedge clk) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Pin pullup
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_pullup_on <= 1'b1;
    end else if (ce) begin
      pin_pullup_on <= !pin_pullup_disable; // RULE10
    end
  end

  // Shared pin pullup
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_pin_pullup_on <= 1'b0;
    end else if (ce) begin
      shared_pin_pullup_on <= shared_pin_int_enable; // RULE13
    end
  end

  // Shared pin direction
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_pin_force_input <= 1'b0;
    end else if (ce) begin
      shared_pin_force_input <= shared_pin_int_enable; // RULE13
    end
  end

  // CPU request
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_irq_request <= 1'b0;
    end else if (ce) begin
      cpu_irq_request <= next_request; // RULE5 RULE9 RULE19
    end
  end

  // Pin level for branch instructions
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_level <= 1'b1;
    end else if (ce) begin
      pin_level <= irq_lvl; // RULE18
    end
  end
endmodule
`default_nettype wire

// ### test/external_interrupt_latch_asserts.sv
// Checker on the latch's pin, request and option outputs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module eil_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic irq_pin_n,
  input wire logic shared_port_pin,
  input wire logic pin_pullup_on,
  input wire logic shared_pin_pullup_on,
  input wire logic shared_pin_force_input,
  input wire logic pin_level,
  // CPU side
  input wire logic vector_fetch,
  input wire logic ccr_int_mask,
  input wire logic cpu_irq_request
);
  default clocking @(posedge clk); endclocking
  AST_RESET_REQ: assert property (rst |=> !cpu_irq_request)
    else $error("request after reset");
  AST_RESET_PULLUP: assert property (rst |=> pin_pullup_on && !shared_pin_force_input)
    else $error("pin options after reset");
  AST_GLOBAL_MASK: assert property (disable iff (rst) ccr_int_mask |=> !cpu_irq_request)
    else $error("request under global mask");
  AST_RISE_UNMASKED: assert property (disable iff (rst) $rose(cpu_irq_request) |-> !$past(ccr_int_mask))
    else $error("request rose while masked");
  AST_SHARED_INPUT: assert property (disable iff (rst) shared_pin_force_input == shared_pin_pullup_on)
    else $error("shared input and pullup differ");
  AST_LEVEL_HIGH: assert property (disable iff (rst) irq_pin_n [*6] |=> pin_level)
    else $error("pin level not high");
  AST_LEVEL_LOW: assert property (disable iff (rst) !irq_pin_n [*6] |=> !pin_level)
    else $error("pin level not low");
  AST_FETCH_CLEARS: assert property (disable iff (rst)
    (irq_pin_n && shared_port_pin) [*8] ##0 vector_fetch |=> ##1 !cpu_irq_request)
    else $error("fetch did not clear");
endmodule
bind external_interrupt_latch eil_chk chk (.clk, .rst, .irq_pin_n, .shared_port_pin, .pin_pullup_on,
  .shared_pin_pullup_on, .shared_pin_force_input, .pin_level, .vector_fetch, .ccr_int_mask, .cpu_irq_request);
`default_nettype wire

// ### test/ext_src.sv
// Push-pull sources on both interrupt pins.
// Assumes the bench asks for a low level; otherwise high.
`timescale 1ns/1ps
`default_nettype none
module ext_src (
  // Requests
  input wire logic irq_low,
  input wire logic shr_low,
  // Pins
  output logic     irq_pin_n,
  output logic     shared_port_pin
);
  assign irq_pin_n = !irq_low;
  assign shared_port_pin = !shr_low;
endmodule
`default_nettype wire

// ### test/external_interrupt_latch_tb.sv
// Bench: register table, then pin scenarios.
// Assumes package, design, source model and checker.
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_latch_tb;
  import ext_irq_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, irq_low, shr_low, irq_pin_n, shared_port_pin;
  logic        vector_fetch, break_state, break_clear_enable, ccr_int_mask, usb_function_enable;
  logic        cpu_irq_request, pin_pullup_on, hresp, pin_level, force_in, shr_pullup;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          err_total, cmp_count;
  localparam logic [7:0] sc = status_control_offset;
  localparam logic [7:0] oc = option_control_offset;
  logic [24:0] rows [4] = '{{sc, 8'h07, 8'h03, 1'b1}, {sc, 8'h00, 8'h00, 1'b1},
    {8'h20, 8'hff, 8'h00, 1'b1}, {oc, 8'h01, 8'h01, 1'b0}};
  external_interrupt_latch dut (.clk, .rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize({1'b0, hsize_word}), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(hresp), .irq_pin_n,
    .shared_port_pin, .pin_pullup_on, .shared_pin_pullup_on(shr_pullup), .shared_pin_force_input(force_in),
    .vector_fetch, .break_state, .break_clear_enable, .ccr_int_mask, .usb_function_enable, .cpu_irq_request,
    .pin_level(pin_level));
  ext_src src (.irq_low, .shr_low, .irq_pin_n, .shared_port_pin);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= htrans_nonseq;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    chk("resp", hresp, 32'h0);
    if (!w) chk("reg", r, {24'h0, d});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d bad %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst, hsel, hwrite, irq_low, shr_low, vector_fetch} = 6'h20;
    {break_state, break_clear_enable, ccr_int_mask, usb_function_enable} = 4'h0;
    {htrans, haddr, hwdata} = '0;
    wt(6);
    rst <= 1'b0;
    wt(2);
    bus(0, sc, 8'h00);
    bus(0, oc, 8'h00);
    chk("pullup", pin_pullup_on, 1'b1);
    chk("level", pin_level, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bus(1, rows[i][24:17], rows[i][16:9]);
      bus(0, rows[i][24:17], rows[i][8:1]);
      chk("pullup", pin_pullup_on, rows[i][0]);
    end
    $display("test table done");
    irq_low <= 1'b1;
    wt(8);
    chk("req", cpu_irq_request, 1'b1);
    chk("level", pin_level, 1'b0);
    bus(1, sc, 8'h02);
    bus(0, sc, 8'h0a);
    chk("req", cpu_irq_request, 1'b0);
    bus(1, sc, 8'h04);
    bus(0, sc, 8'h00);
    irq_low <= 1'b0;
    wt(8);
    irq_low <= 1'b1;
    wt(8);
    chk("req", cpu_irq_request, 1'b1);
    irq_low <= 1'b0;
    wt(9);
    vector_fetch <= 1'b1;
    wt(1);
    vector_fetch <= 1'b0;
    wt(3);
    chk("req", cpu_irq_request, 1'b0);
    $display("test edge done");
    bus(1, sc, 8'h01);
    irq_low <= 1'b1;
    wt(8);
    bus(1, sc, 8'h07);
    bus(0, sc, 8'h0b);
    irq_low <= 1'b0;
    wt(8);
    bus(0, sc, 8'h03);
    irq_low <= 1'b1;
    wt(8);
    rst <= 1'b1;
    wt(1);
    rst <= 1'b0;
    wt(1);
    chk("req", cpu_irq_request, 1'b0);
    bus(0, sc, 8'h00);
    irq_low <= 1'b0;
    wt(8);
    bus(1, sc, 8'h04);
    $display("test level done");
    irq_low <= 1'b1;
    wt(8);
    ccr_int_mask <= 1'b1;
    wt(2);
    chk("req", cpu_irq_request, 1'b0);
    {break_state, ccr_int_mask} <= 2'h2;
    bus(1, sc, 8'h04);
    bus(0, sc, 8'h08);
    break_clear_enable <= 1'b1;
    bus(1, sc, 8'h04);
    {break_state, break_clear_enable, irq_low} <= 3'h0;
    bus(0, sc, 8'h00);
    $display("test break done");
    bus(1, oc, 8'h02);
    shr_low <= 1'b1;
    wt(8);
    chk("req", cpu_irq_request, 1'b1);
    chk("force", force_in, 1'b1);
    chk("shrpull", shr_pullup, 1'b1);
    bus(0, oc, 8'h06);
    bus(0, oc, 8'h02);
    bus(1, sc, 8'h04);
    {shr_low, usb_function_enable} <= 2'h1;
    wt(8);
    shr_low <= 1'b1;
    wt(8);
    bus(0, sc, 8'h00);
    $display("test shared done");
    give_verdict();
  end
endmodule
`default_nettype wire
